// >>> common/hel_pkg.sv
package hel_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int INFO_W = 32;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [NUM_BANKS-1:0] EN_RESET = 4'h0;

  typedef enum logic [1:0] {
    HEL_CLS_CORR = 2'h0,
    HEL_CLS_DEFER = 2'h1,
    HEL_CLS_UNCORR = 2'h2,
    HEL_CLS_FATAL = 2'h3
  } hel_class_t;

  typedef struct packed {
    logic valid;
    logic [BANK_W-1:0] bank;
    logic correctable;
    logic deferrable;
    logic fatal;
    logic [INFO_W-1:0] info;
  } hel_err_t;

  typedef struct packed {
    logic valid;
    hel_class_t cls;
    logic poisoned;
    logic [INFO_W-1:0] info;
  } hel_log_t;
endpackage

// >>> src/hel_bank_store.sv
`timescale 1ns/1ps
`default_nettype none
module hel_bank_store (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [hel_pkg::BANK_W-1:0] wrBank,
  input wire hel_pkg::hel_log_t wrData,
  input wire logic clrEn,
  input wire logic [hel_pkg::BANK_W-1:0] clrBank,
  input wire logic [hel_pkg::BANK_W-1:0] rdBank,
  output hel_pkg::hel_log_t rdData
);
  // no reset on purpose: logged errors must survive a warm reset
  hel_pkg::hel_log_t mem_q [hel_pkg::NUM_BANKS];
  hel_pkg::hel_log_t rdData_q;

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem_q[wrBank] <= wrData;
    end else if (clrEn) begin
      mem_q[clrBank].valid <= 1'b0;
    end
    rdData_q <= mem_q[rdBank];
  end

  assign rdData = rdData_q;
endmodule
`default_nettype wire

// >>> src/hel_error_log.sv
// Operation
// - enabled bank stores detected error info; disabled bank drops it.
// - uncorrected error raises machine check only if source reporting enabled.
// - per-source reporting enables; logging continues when reporting off.
// - software may disable autonomous correction/containment per source.
// - every error classed corrected, deferred, uncorrected or fatal.
// - corrected errors never raise machine check; logged if enabled.
// - deferred errors logged if enabled, not reported by machine check at detection.
// - deferred error escalates to uncorrected on consumption, then reports.
// - uncorrectable memory data marked poisoned, machine check on consumption.
// - uncontainable error forces core shutdown.
// - optional interrupt on first detection of a deferred error.
// - count logged corrected errors; interrupt once count exceeds threshold.
// - both interrupts independent of machine check path and its enables.
// - logged registers keep contents across warm reset.
`timescale 1ns/1ps
`default_nettype none
module hel_error_log (
  input wire logic clk,
  input wire logic rst,
  input wire logic coldRst,
  input wire hel_pkg::hel_err_t errIn,
  input wire logic consumeValid,
  input wire logic [hel_pkg::BANK_W-1:0] consumeBank,
  input wire logic [hel_pkg::NUM_BANKS-1:0] bankLogEn,
  input wire logic [hel_pkg::NUM_BANKS-1:0] reportEn,
  input wire logic [hel_pkg::NUM_BANKS-1:0] corrActionDis,
  input wire logic deferIntEn,
  input wire logic threshIntEn,
  input wire logic [hel_pkg::CNT_W-1:0] threshold,
  input wire logic cntWrite,
  input wire logic [hel_pkg::CNT_W-1:0] cntWrData,
  input wire logic statusClr,
  input wire logic [hel_pkg::BANK_W-1:0] statusBank,
  input wire logic [hel_pkg::BANK_W-1:0] rdBank,
  output hel_pkg::hel_log_t rdData,
  output logic [hel_pkg::NUM_BANKS-1:0] corrActionEn,
  output logic machineCheckException,
  output logic shutdownReq,
  output logic deferInt,
  output logic threshInt,
  output logic [hel_pkg::CNT_W-1:0] corrCount
);
  logic [hel_pkg::NUM_BANKS-1:0] deferPend_q, deferPend_d;
  logic [hel_pkg::NUM_BANKS-1:0] deferSet, deferHit;
  logic [hel_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic mce_q, mce_d;
  logic shut_q, shut_d;
  logic dInt_q, dInt_d;
  logic tInt_q, tInt_d;
  hel_pkg::hel_class_t cls;
  logic logIt, escLog, anyHit, corrLogged;
  logic [hel_pkg::BANK_W-1:0] wrBank;
  hel_pkg::hel_log_t wrData;

  // classification of the incoming error
  always_comb begin
    if (errIn.fatal) begin
      cls = hel_pkg::HEL_CLS_FATAL;
    end else if (errIn.correctable && !corrActionDis[errIn.bank]) begin
      cls = hel_pkg::HEL_CLS_CORR;
    end else if (errIn.deferrable && !corrActionDis[errIn.bank]) begin
      cls = hel_pkg::HEL_CLS_DEFER;
    end else begin
      cls = hel_pkg::HEL_CLS_UNCORR;
    end
  end

  assign corrActionEn = ~corrActionDis;
  assign logIt = errIn.valid && bankLogEn[errIn.bank];
  assign anyHit = |deferHit;
  // escalation rewrites the consumed bank unless a new error owns the write port
  assign escLog = anyHit && !logIt;
  assign corrLogged = logIt && (cls == hel_pkg::HEL_CLS_CORR);

  // per-bank deferred tracking; a new deferred error wins over a same-cycle consumption
  for (genvar b = 0; b < hel_pkg::NUM_BANKS; b++) begin : g_pend
    assign deferSet[b] = errIn.valid && (cls == hel_pkg::HEL_CLS_DEFER)
      && (errIn.bank == hel_pkg::BANK_W'(b));
    assign deferHit[b] = consumeValid && deferPend_q[b]
      && (consumeBank == hel_pkg::BANK_W'(b));
    assign deferPend_d[b] = deferSet[b] || (deferPend_q[b] && !deferHit[b]);
  end

  always_comb begin
    wrData.valid = 1'b1;
    if (logIt) begin
      wrData.cls = cls;
      wrData.poisoned = (cls == hel_pkg::HEL_CLS_DEFER);
      wrData.info = errIn.info;
      wrBank = errIn.bank;
    end else begin
      // escalated entry: detail is dropped but the data stays marked poisoned
      wrData.cls = hel_pkg::HEL_CLS_UNCORR;
      wrData.poisoned = 1'b1;
      wrData.info = '0;
      wrBank = consumeBank;
    end
  end

  hel_bank_store store (
    .clk(clk),
    .wrEn(logIt || escLog),
    .wrBank(wrBank),
    .wrData(wrData),
    .clrEn(statusClr),
    .clrBank(statusBank),
    .rdBank(rdBank),
    .rdData(rdData)
  );

  // machine check and shutdown; reporting gated by the per-source enables
  always_comb begin
    mce_d = 1'b0;
    shut_d = shut_q;
    if (anyHit) begin
      mce_d = reportEn[consumeBank];
    end
    if (errIn.valid) begin
      unique case (cls)
        hel_pkg::HEL_CLS_UNCORR: begin
          mce_d = mce_d || reportEn[errIn.bank];
        end
        hel_pkg::HEL_CLS_FATAL: begin
          shut_d = 1'b1;
          mce_d = mce_d || reportEn[errIn.bank];
        end
        hel_pkg::HEL_CLS_CORR, hel_pkg::HEL_CLS_DEFER: begin
          // no exception on detection; deferred ones wait for consumption
        end
      endcase
    end
  end

  // counter saturates; a software write beats a same-cycle increment
  always_comb begin
    cnt_d = cnt_q;
    if (corrLogged && cnt_q != hel_pkg::CNT_MAX) begin
      cnt_d = cnt_q + 16'h0001;
    end
    if (cntWrite) begin
      cnt_d = cntWrData;
    end
  end

  // notification pulses, independent of the machine-check enables
  always_comb begin
    dInt_d = deferIntEn && |(deferSet & ~deferPend_q);
    // pulse on the step that carries the count past the threshold
    tInt_d = threshIntEn && (cnt_d > threshold) && (cnt_q <= threshold);
  end

  // warm reset clears tracking and pulses only
  always_ff @(posedge clk) begin
    if (rst) begin
      deferPend_q <= hel_pkg::EN_RESET;
      mce_q <= 1'b0;
      dInt_q <= 1'b0;
      tInt_q <= 1'b0;
    end else begin
      deferPend_q <= deferPend_d;
      mce_q <= mce_d;
      dInt_q <= dInt_d;
      tInt_q <= tInt_d;
    end
  end

  // counter and shutdown survive a warm reset so boot code can still read them
  always_ff @(posedge clk) begin
    if (coldRst) begin
      cnt_q <= hel_pkg::CNT_RESET;
      shut_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      shut_q <= shut_d;
    end
  end

  assign machineCheckException = mce_q;
  assign shutdownReq = shut_q;
  assign deferInt = dInt_q;
  assign threshInt = tInt_q;
  assign corrCount = cnt_q;
endmodule
`default_nettype wire

// >>> verif/hel_err_src.sv
`timescale 1ns/1ps
`default_nettype none
module hel_err_src (
  input wire logic clk,
  input wire logic fire,
  input wire hel_pkg::hel_class_t kind,
  input wire logic [1:0] bank,
  output hel_pkg::hel_err_t errIn
);
  // idle info toggles so a stale value is never mistaken for a fresh one
  logic [31:0] idle_q = 32'h0;
  always_ff @(posedge clk) idle_q <= ~idle_q;
  assign errIn = {fire, bank, kind == hel_pkg::HEL_CLS_CORR, kind == hel_pkg::HEL_CLS_DEFER,
    kind == hel_pkg::HEL_CLS_FATAL, fire ? {30'h0, bank} : idle_q};
endmodule
`default_nettype wire

// >>> verif/hel_error_log_props.sv
`timescale 1ns/1ps
`default_nettype none
module hel_error_log_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic coldRst,
  input wire hel_pkg::hel_err_t errIn,
  input wire logic consumeValid,
  input wire logic [3:0] bankLogEn,
  input wire logic [3:0] reportEn,
  input wire logic [3:0] corrActionDis,
  input wire logic deferIntEn,
  input wire logic threshIntEn,
  input wire logic [15:0] threshold,
  input wire logic cntWrite,
  input wire logic [15:0] cntWrData,
  input wire logic machineCheckException,
  input wire logic shutdownReq,
  input wire logic deferInt,
  input wire logic threshInt,
  input wire logic [15:0] corrCount
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || coldRst);
  sequence unc_s;
    errIn.valid && !errIn.correctable && !errIn.deferrable && !errIn.fatal;
  endsequence
  uncorr_report_a: assert property (unc_s ##0 reportEn[errIn.bank] |=> machineCheckException)
    else $error("uncorrected error not reported");
  report_off_a: assert property (errIn.valid && !reportEn[errIn.bank] && !consumeValid
    |=> !machineCheckException) else $error("report while disabled");
  defer_int_a: assert property (deferInt |-> $past(deferIntEn) && $past(errIn.deferrable))
    else $error("stray deferred interrupt");
  thresh_int_a: assert property (threshInt |-> $past(threshIntEn) && corrCount > threshold)
    else $error("stray threshold interrupt");
  count_step_a: assert property (errIn.valid && errIn.correctable && !errIn.fatal && !cntWrite
    && bankLogEn[errIn.bank] && !corrActionDis[errIn.bank] && corrCount != 16'hFFFF
    |=> corrCount == $past(corrCount) + 16'h1) else $error("count missed");
  count_sat_a: assert property (corrCount == 16'hFFFF && !cntWrite |=> corrCount == 16'hFFFF)
    else $error("counter wrapped");
  count_load_a: assert property (cntWrite |=> corrCount == $past(cntWrData))
    else $error("counter load lost");
  shutdown_hold_a: assert property (shutdownReq |=> shutdownReq)
    else $error("shutdown dropped");
endmodule
bind hel_error_log hel_error_log_props props_u (.*);
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst = 1, coldRst = 1, fire = 0, consumeValid = 0, statusClr = 0;
  logic deferIntEn = 0, threshIntEn = 0, cntWrite = 0;
  logic [1:0] bank = 0;
  logic [3:0] bankLogEn = 4'hF, reportEn = 4'hF, corrActionDis = 4'h0, corrActionEn;
  logic [15:0] threshold = 16'h2, cntWrData = 16'h0, corrCount;
  logic machineCheckException, shutdownReq, deferInt, threshInt;
  hel_pkg::hel_class_t kind = hel_pkg::HEL_CLS_CORR;
  hel_pkg::hel_err_t errIn;
  hel_pkg::hel_log_t rdData;
  int fail_count = 0, samples_checked = 0;
  always #2 clk = ~clk;
  hel_err_src src_u (.*);
  hel_error_log dut_u (.consumeBank(bank), .statusBank(bank), .rdBank(bank), .*);
  task summarize();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle error; returns where the answer of the taking edge has landed
  task err(input hel_pkg::hel_class_t k, input logic [1:0] b);
    @(negedge clk) fire = 1;
    kind = k;
    bank = b;
    @(negedge clk) fire = 0;
  endtask
  task log_is(input logic [1:0] b, input logic [3:0] e);
    @(negedge clk) bank = b;
    @(negedge clk) cmp("log", e, {rdData.valid, rdData.cls, rdData.poisoned});
  endtask
  task load(input logic [15:0] v);
    @(negedge clk) cntWrite = 1;
    cntWrData = v;
    @(negedge clk) cntWrite = 0;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    coldRst = 0;
    err(hel_pkg::HEL_CLS_UNCORR, 1);
    cmp("mce", 1, machineCheckException);
    log_is(1, 4'b1100);
    reportEn = 4'hB;
    err(hel_pkg::HEL_CLS_UNCORR, 2);
    cmp("mce", 0, machineCheckException);
    log_is(2, 4'b1100);
    cmp("info", 32'h2, rdData.info);
    err(hel_pkg::HEL_CLS_UNCORR, 3);
    bankLogEn = 4'h7;
    @(negedge clk) statusClr = 1;
    bank = 3;
    @(negedge clk) statusClr = 0;
    err(hel_pkg::HEL_CLS_UNCORR, 3);
    log_is(3, 4'b0100);
    reportEn = 4'h0;
    threshIntEn = 1;
    load(16'h2);
    err(hel_pkg::HEL_CLS_CORR, 0);
    cmp("mce", 0, machineCheckException);
    cmp("thr", 1, threshInt);
    cmp("cnt", 3, corrCount);
    deferIntEn = 1;
    err(hel_pkg::HEL_CLS_DEFER, 1);
    cmp("dint", 3'b100, {deferInt, machineCheckException, 1'b0});
    reportEn = 4'hF;
    @(negedge clk) consumeValid = 1;
    @(negedge clk) consumeValid = 0;
    cmp("mce", 1, machineCheckException);
    log_is(1, 4'b1101);
    load(16'hFFFF);
    err(hel_pkg::HEL_CLS_CORR, 0);
    cmp("cnt", 16'hFFFF, corrCount);
    err(hel_pkg::HEL_CLS_FATAL, 2);
    cmp("shut", 1, shutdownReq);
    @(negedge clk) rst = 1;
    @(negedge clk) rst = 0;
    cmp("shut", 1, shutdownReq);
    log_is(1, 4'b1101);
    corrActionDis = 4'h5;
    #1 cmp("act", 4'hA, corrActionEn);
    err(hel_pkg::HEL_CLS_CORR, 0);
    cmp("mce", 1, machineCheckException);
    log_is(0, 4'b1100);
    @(negedge clk) coldRst = 1;
    @(negedge clk) coldRst = 0;
    cmp("cold", 0, {shutdownReq, corrCount});
    summarize();
  end
  initial begin
    #20000 fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
